// ---- ppm_consts.svh ----
`ifndef PPM_CONSTS_SVH
`define PPM_CONSTS_SVH
// Overview of operation
// R1: The four shared pins of port seven are common lines seven to four while the share select bit is 0 and segment lines sixteen to nineteen while it is 1.
// R2: A port pin drives when its direction bit is 1 and is an input when it is 0.
// R3: Pull-up and open-drain choices are set per pin by software, apart from direction.
// R4: The single pin of port one also offers a Schmitt-trigger input mode.
// R5: Port five is eight bits wide and each pin can be switched alone to segment line zero to seven.
// R6: Port six is eight bits wide and each pin can be switched alone to segment line eight to fifteen.
// R7: Port seven pins are digital inputs only, each switchable alone to a segment or common output.
// R8: Port zero carries the timer zero event input on pin one, the buzzer on pin four and interrupt inputs zero and one on pins six and seven.
// R9: The pin of port one carries either the timer three PWM output or the timer two output.
// R10: Port two pins double as analog inputs zero to five, and the small package has only four.
// R11: Port four is seven bits wide with interrupts two and three on pins one and four, main oscillator on two and three, sub oscillator on five and six and reset on seven.
// R12: Port five pins zero, one and two also carry UART receive, transmit and external clock.
// R13: A pin in segment, common or other alternate output mode drives the alternate signal and ignores its output latch.
// R14: Shared LCD pins leave reset as general-purpose inputs until software selects their LCD function.

// ==========================================================
// register map, byte addresses
`define PPM_PORT_STRIDE   8'h10
`define PPM_OFS_PORT_LAST 8'h6C
`define PPM_OFS_SEG5      8'h80
`define PPM_OFS_SEG6      8'h84
`define PPM_OFS_SEG7      8'h88
`define PPM_OFS_LCD_CTRL  8'h8C
`define PPM_OFS_ALT_CTRL  8'h90
`define PPM_OFS_ANA_SEL   8'h94

// ==========================================================
// field positions
`define PPM_BIT_SHARE     0
`define PPM_BIT_BUZ_EN    0
`define PPM_BIT_P1_ALT    1
`define PPM_BIT_P1_T2     2
`define PPM_BIT_TX_EN     3
`define PPM_BIT_MOSC      4
`define PPM_BIT_SOSC      5
`define PPM_BIT_P1_SCHM   6

// ==========================================================
// reset values
`define PPM_RST_PORT      8'h00
`define PPM_RST_SEG       8'h00
`define PPM_RST_LCD_CTRL  8'h00
`define PPM_RST_ALT_CTRL  8'h30
`define PPM_RST_ANA_SEL   8'h00

// ==========================================================
// implemented pins per port slot
`define PPM_MASK_P0       8'hD2
`define PPM_MASK_P1       8'h01
`define PPM_MASK_P2_BIG   8'h3F
`define PPM_MASK_P2_SMALL 8'h0F
`define PPM_MASK_P4       8'hFE
`define PPM_MASK_P4_DIR   8'h7E
`define PPM_MASK_FULL     8'hFF
`define PPM_MASK_NONE     8'h00
`define PPM_MASK_MOSC     8'h0C
`define PPM_MASK_SOSC     8'h60
`endif

// ---- ppm_pkg.sv ----
package ppm_pkg;
  typedef logic [7:0] ppm_byte_t;
  typedef logic [2:0] ppm_slot_t;
  typedef enum logic [1:0] {
    FLD_DATA = 2'h0,
    FLD_DIR  = 2'h1,
    FLD_PULL = 2'h2,
    FLD_OD   = 2'h3
  } ppm_field_e;
endpackage : ppm_pkg

// ---- ppm_sync3.sv ----
`timescale 1ns/10ps
module ppm_sync3 import ppm_pkg::*; #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  // asynchronous levels and their filtered copy
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);
  logic [W-1:0] st1_q;
  logic [W-1:0] st2_q;
  logic [W-1:0] st3_q;
  // a change is taken only once stages two and three agree
  wire  [W-1:0] agree = ~(st2_q ^ st3_q);

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st1_q   <= '0;
      st2_q   <= '0;
      st3_q   <= '0;
      syncOut <= '0;
    end else begin
      st1_q   <= asyncIn;
      st2_q   <= st1_q;
      st3_q   <= st2_q;
      syncOut <= (agree & st3_q) | (~agree & syncOut);
    end
  end
endmodule : ppm_sync3

// ---- ppm_wb_slave.sv ----
`timescale 1ns/10ps
module ppm_wb_slave import ppm_pkg::*; (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // wishbone request
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  // wishbone answer
  output logic             wb_ack_o,
  output logic      [31:0] wb_dat_o,
  // register file side
  input  wire ppm_byte_t   rdByte,
  output logic             wrStb
);
  wire req = wb_cyc_i & wb_stb_i;

  // write lands on the edge where the master sees ack
  assign wrStb = req & wb_we_i & wb_sel_i[0] & wb_ack_o;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
      if (req && !wb_ack_o) begin
        wb_dat_o <= {24'h00_0000, rdByte};
      end
    end
  end
endmodule : ppm_wb_slave

// ---- ppm_pin_mux.sv ----
`timescale 1ns/10ps
`include "ppm_consts.svh"
module ppm_pin_mux import ppm_pkg::*; #(
  parameter bit SMALL_PACKAGE = 1'b0
) (
  // clock and reset
  input  wire logic            sys_clk,
  input  wire logic            rstn,
  // wishbone register bus
  input  wire logic            wb_cyc_i,
  input  wire logic            wb_stb_i,
  input  wire logic            wb_we_i,
  input  wire logic [7:0]      wb_adr_i,
  input  wire logic [31:0]     wb_dat_i,
  input  wire logic [3:0]      wb_sel_i,
  output logic                 wb_ack_o,
  output logic      [31:0]     wb_dat_o,
  // pads, slots 0..6 are ports 0,1,2,4,5,6,7
  input  wire logic [6:0][7:0] padIn,
  output logic      [6:0][7:0] padOut,
  output logic      [6:0][7:0] padOe,
  output logic      [6:0][7:0] padPullUp,
  output logic                 port1SchmittEn,
  output logic      [5:0]      analogInputSelect,
  output logic                 mainOscEnable,
  output logic                 subOscEnable,
  // lcd driver
  input  wire logic [19:0]     lcdSegmentLines,
  input  wire logic [7:0]      lcdCommonLines,
  // peripheral signals towards the pins
  input  wire logic            buzzerOutput,
  input  wire logic            timer3PwmOut,
  input  wire logic            timer2Output,
  input  wire logic            uartTransmitOut,
  // pin levels towards peripherals
  output logic                 timer0EventInput,
  output logic                 extIrqZero,
  output logic                 extIrqOne,
  output logic                 extIrqTwo,
  output logic                 extIrqThree,
  output logic                 uartReceiveIn,
  output logic                 uartClockIn,
  output logic                 resetPinLevel
);
  // ==========================================================
  // pin masks
  function automatic ppm_byte_t pinMask(input ppm_slot_t s);
    unique case (s)
      3'd0:    pinMask = `PPM_MASK_P0;
      3'd1:    pinMask = `PPM_MASK_P1;
      3'd2:    pinMask = SMALL_PACKAGE ? `PPM_MASK_P2_SMALL
                                       : `PPM_MASK_P2_BIG; // R10
      3'd3:    pinMask = `PPM_MASK_P4; // R11
      3'd4:    pinMask = `PPM_MASK_FULL; // R5
      3'd5:    pinMask = `PPM_MASK_FULL; // R6
      3'd6:    pinMask = `PPM_MASK_FULL;
      default: pinMask = `PPM_MASK_NONE;
    endcase
  endfunction : pinMask

  // latch bits software may write; port 7 and the reset pin never drive from the latch
  function automatic ppm_byte_t ctlMask(input ppm_slot_t s);
    unique case (s)
      3'd3:    ctlMask = `PPM_MASK_P4_DIR; // R11
      3'd6:    ctlMask = `PPM_MASK_NONE; // R7
      default: ctlMask = pinMask(s);
    endcase
  endfunction : ctlMask

  // one control register hit, offsets come from the header
  function automatic logic hitAt(input ppm_byte_t a, input ppm_byte_t ofs);
    hitAt = (a == ofs);
  endfunction : hitAt

  // ==========================================================
  // registers
  ppm_byte_t [6:0] data_q;
  ppm_byte_t [6:0] dir_q;
  ppm_byte_t [6:0] pull_q;
  ppm_byte_t [6:0] od_q;
  ppm_byte_t       seg5_q;
  ppm_byte_t       seg6_q;
  ppm_byte_t       seg7_q;
  ppm_byte_t       lcdCtrl_q;
  ppm_byte_t       altCtrl_q;
  ppm_byte_t       anaSel_q;
  logic [6:0][7:0] pinLvl;

  // ==========================================================
  // pad input synchroniser
  // three stages keep a metastable first flop out of the vote
  ppm_sync3 #(
    .W(56)
  ) u_sync (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .asyncIn (padIn),
    .syncOut (pinLvl)
  );

  // ==========================================================
  // bus decode
  ppm_byte_t  rdByte;
  logic       wrStb;
  wire  ppm_slot_t  slot   = wb_adr_i[6:4];
  wire  ppm_field_e fld    = ppm_field_e'(wb_adr_i[3:2]);
  wire  ppm_byte_t  wByte  = wb_dat_i[7:0];
  wire  ppm_byte_t  wMask  = ctlMask(slot);
  wire  ppm_byte_t  wLatch = wByte & wMask;
  wire  portHit = (wb_adr_i <= `PPM_OFS_PORT_LAST) &&
                  (wb_adr_i[1:0] == 2'h0);
  wire  hitSeg5 = hitAt(wb_adr_i, `PPM_OFS_SEG5);
  wire  hitSeg6 = hitAt(wb_adr_i, `PPM_OFS_SEG6);
  wire  hitSeg7 = hitAt(wb_adr_i, `PPM_OFS_SEG7);
  wire  hitLcd  = hitAt(wb_adr_i, `PPM_OFS_LCD_CTRL);
  wire  hitAlt  = hitAt(wb_adr_i, `PPM_OFS_ALT_CTRL);
  wire  hitAna  = hitAt(wb_adr_i, `PPM_OFS_ANA_SEL);
  wire  wrPort  = wrStb & portHit;

  ppm_wb_slave u_wb (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_sel_i (wb_sel_i),
    .wb_ack_o (wb_ack_o),
    .wb_dat_o (wb_dat_o),
    .rdByte   (rdByte),
    .wrStb    (wrStb)
  );

  // ==========================================================
  // control fields
  wire shareSeg = lcdCtrl_q[`PPM_BIT_SHARE];
  wire buzEn    = altCtrl_q[`PPM_BIT_BUZ_EN];
  wire p1AltEn  = altCtrl_q[`PPM_BIT_P1_ALT];
  wire p1UseT2  = altCtrl_q[`PPM_BIT_P1_T2];
  wire txEn     = altCtrl_q[`PPM_BIT_TX_EN];
  wire moscEn   = altCtrl_q[`PPM_BIT_MOSC];
  wire soscEn   = altCtrl_q[`PPM_BIT_SOSC];
  wire p1Schm   = altCtrl_q[`PPM_BIT_P1_SCHM];
  wire ppm_byte_t anaMask = anaSel_q & pinMask(3'd2);

  // ==========================================================
  // alternate output selection
  logic [6:0][7:0] altEn;
  logic [6:0][7:0] altVal;
  logic [6:0][7:0] offMask;
  wire  [3:0]      p7Low = shareSeg ? lcdSegmentLines[19:16]
                                    : {lcdCommonLines[4],
                                       lcdCommonLines[5],
                                       lcdCommonLines[6],
                                       lcdCommonLines[7]}; // R1
  wire  [3:0]      p7High = {lcdCommonLines[0], lcdCommonLines[1],
                             lcdCommonLines[2], lcdCommonLines[3]};
  // a segment select takes the transmit pin away from the uart
  wire  ppm_byte_t txBit  = {6'h00, txEn & ~seg5_q[1], 1'b0}; // R12

  assign altEn[0]  = {3'h0, buzEn, 4'h0}; // R8
  assign altVal[0] = {3'h0, buzzerOutput, 4'h0}; // R8
  assign altEn[1]  = {7'h00, p1AltEn}; // R9
  assign altVal[1] = {7'h00, p1UseT2 ? timer2Output
                                     : timer3PwmOut}; // R9
  assign altEn[2]  = 8'h00;
  assign altVal[2] = 8'h00;
  assign altEn[3]  = 8'h00;
  assign altVal[3] = 8'h00;
  assign altEn[4]  = seg5_q | txBit; // R5
  assign altVal[4] = (seg5_q & lcdSegmentLines[7:0]) |
                     (txBit & {6'h00, uartTransmitOut, 1'b0}); // R12
  assign altEn[5]  = seg6_q; // R6
  assign altVal[5] = lcdSegmentLines[15:8]; // R6
  assign altEn[6]  = seg7_q; // R7
  assign altVal[6] = {p7High, p7Low}; // R1

  // analog and oscillator pins drop their digital role
  assign offMask[0] = 8'h00;
  assign offMask[1] = 8'h00;
  assign offMask[2] = anaMask; // R10
  assign offMask[3] = (moscEn ? `PPM_MASK_MOSC : 8'h00) |
                      (soscEn ? `PPM_MASK_SOSC : 8'h00); // R11
  assign offMask[4] = 8'h00;
  assign offMask[5] = 8'h00;
  assign offMask[6] = 8'h00;

  // ==========================================================
  // pad drive
  logic [6:0][7:0] gpioM;
  logic [6:0][7:0] drv;
  logic [6:0][7:0] outVal;
  logic [6:0][7:0] oeVal;
  logic [6:0][7:0] pullVal;
  logic [6:0][7:0] rdPin;

  for (genvar s = 0; s < 7; s++) begin : g_slot
    assign gpioM[s]   = pinMask(3'(s)) & ~offMask[s];
    // alternate output beats the latch
    assign drv[s]     = altEn[s] |
                        (dir_q[s] & gpioM[s] & ctlMask(3'(s))); // R2 R13
    assign outVal[s]  = (altEn[s] & altVal[s]) |
                        (~altEn[s] & data_q[s]); // R13
    // open drain only releases gpio highs; lcd lines need push-pull
    assign oeVal[s]   = drv[s] & ~(od_q[s] & ~altEn[s] & outVal[s]); // R3
    assign pullVal[s] = pull_q[s] & gpioM[s] & ~altEn[s]; // R3
    assign rdPin[s]   = pinLvl[s] & gpioM[s] & ~altEn[s];
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      padOut    <= '0;
      padOe     <= '0;
      padPullUp <= '0;
    end else begin
      padOut    <= outVal & oeVal;
      padOe     <= oeVal;
      padPullUp <= pullVal;
    end
  end

  // ==========================================================
  // pin levels to peripherals; inputs work in any direction
  assign timer0EventInput  = pinLvl[0][1]; // R8
  assign extIrqZero        = pinLvl[0][6]; // R8
  assign extIrqOne         = pinLvl[0][7]; // R8
  assign extIrqTwo         = pinLvl[3][1]; // R11
  assign extIrqThree       = pinLvl[3][4]; // R11
  assign resetPinLevel     = pinLvl[3][7]; // R11
  // receive idles high and clock idles low while the pin serves the lcd
  assign uartReceiveIn     = pinLvl[4][0] | seg5_q[0]; // R12
  assign uartClockIn       = pinLvl[4][2] & ~seg5_q[2]; // R12
  assign port1SchmittEn    = p1Schm & ~dir_q[1][0]; // R4
  assign analogInputSelect = anaMask[5:0]; // R10
  assign mainOscEnable     = moscEn; // R11
  assign subOscEnable      = soscEn; // R11

  // ==========================================================
  // read selection, unmapped reads as zero
  // data reads show the pin, so an open-drain wired-and is visible
  wire ppm_byte_t portRd = (fld == FLD_DATA) ? rdPin[slot]  :
                           (fld == FLD_DIR)  ? dir_q[slot]  :
                           (fld == FLD_PULL) ? pull_q[slot] :
                                               od_q[slot];
  assign rdByte = portHit ? portRd    :
                  hitSeg5 ? seg5_q    :
                  hitSeg6 ? seg6_q    :
                  hitSeg7 ? seg7_q    :
                  hitLcd  ? lcdCtrl_q :
                  hitAlt  ? altCtrl_q :
                  hitAna  ? anaSel_q  : 8'h00;

  // ==========================================================
  // port registers
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      data_q <= {7{`PPM_RST_PORT}};
      dir_q  <= {7{`PPM_RST_PORT}}; // R14
      pull_q <= {7{`PPM_RST_PORT}};
      od_q   <= {7{`PPM_RST_PORT}};
    end else if (wrPort) begin
      unique case (fld)
        FLD_DATA: data_q[slot] <= wLatch;
        FLD_DIR:  dir_q[slot]  <= wLatch; // R2
        FLD_PULL: pull_q[slot] <= wLatch; // R3
        FLD_OD:   od_q[slot]   <= wLatch; // R3
      endcase
    end
  end

  // ==========================================================
  // lcd and alternate control registers
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      seg5_q    <= `PPM_RST_SEG; // R14
      seg6_q    <= `PPM_RST_SEG; // R14
      seg7_q    <= `PPM_RST_SEG; // R14
      lcdCtrl_q <= `PPM_RST_LCD_CTRL;
      // oscillators own their pins from reset so the clock can start
      altCtrl_q <= `PPM_RST_ALT_CTRL;
      anaSel_q  <= `PPM_RST_ANA_SEL;
    end else if (wrStb) begin
      if (hitSeg5) begin
        seg5_q <= wByte; // R5
      end
      if (hitSeg6) begin
        seg6_q <= wByte; // R6
      end
      if (hitSeg7) begin
        seg7_q <= wByte; // R7
      end
      if (hitLcd) begin
        lcdCtrl_q <= {7'h00, wByte[`PPM_BIT_SHARE]}; // R1
      end
      if (hitAlt) begin
        altCtrl_q <= {1'b0, wByte[6:0]};
      end
      if (hitAna) begin
        anaSel_q <= wByte & pinMask(3'd2); // R10
      end
    end
  end
endmodule : ppm_pin_mux

// ---- ppm_pin_mux_chk.sv ----
`timescale 1ns/10ps
module ppm_pin_mux_chk import ppm_pkg::*; (
  // clock and reset
  input wire logic            sys_clk,
  input wire logic            rstn,
  // bus handshake
  input wire logic            wb_cyc_i,
  input wire logic            wb_stb_i,
  input wire logic            wb_ack_o,
  // pads and peripherals
  input wire logic [6:0][7:0] padIn,
  input wire logic [6:0][7:0] padOut,
  input wire logic [6:0][7:0] padOe,
  input wire logic [7:0]      lcdCommonLines,
  input wire logic            mainOscEnable,
  input wire logic            subOscEnable,
  input wire logic            timer0EventInput,
  input wire logic            extIrqTwo
);
  // ======
  // cycles since reset, masks the synchroniser fill
  logic [2:0] upCnt_q;
  always_ff @(posedge sys_clk) begin
    if (!rstn) upCnt_q <= 3'h0;
    else if (upCnt_q != 3'h7) upCnt_q <= upCnt_q + 3'h1;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence s_taken;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_steady(sig);
    $stable(sig) [*6];
  endsequence
  property p_sync(sig, lvl);
    s_steady(sig) ##0 (upCnt_q == 3'h7) |-> lvl == sig;
  endproperty
  // ======
  // checks
  a_ack_next: assert property (s_taken |=> wb_ack_o)
    else $error("no ack after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_reset_quiet: assert property (
    $past(!rstn) |-> padOe == '0 && padOut == '0)
    else $error("pads driven after reset");
  a_osc_reset: assert property (
    $past(!rstn) |-> mainOscEnable && subOscEnable)
    else $error("oscillators off after reset");
  a_p7_com: assert property (
    padOe[6][5] |-> padOut[6][5] == $past(lcdCommonLines[2]))
    else $error("port seven common line wrong");
  a_t0_sync: assert property (p_sync(padIn[0][1], timer0EventInput))
    else $error("event input not following pin");
  a_irq2_sync: assert property (p_sync(padIn[3][1], extIrqTwo))
    else $error("interrupt two not following pin");
endmodule : ppm_pin_mux_chk

bind ppm_pin_mux ppm_pin_mux_chk i_ppm_pin_mux_chk (
  .sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .padIn(padIn),
  .padOut(padOut), .padOe(padOe), .lcdCommonLines(lcdCommonLines),
  .mainOscEnable(mainOscEnable), .subOscEnable(subOscEnable),
  .timer0EventInput(timer0EventInput), .extIrqTwo(extIrqTwo));

// ---- ppm_pad_model.sv ----
`timescale 1ns/10ps
module ppm_pad_model import ppm_pkg::*; (
  // device side
  input  wire logic [6:0][7:0] padOut,
  input  wire logic [6:0][7:0] padOe,
  input  wire logic [6:0][7:0] padPullUp,
  // board level on released pins
  input  wire logic [6:0][7:0] extLvl,
  output logic      [6:0][7:0] padIn
);
  // ======
  // driver wins, then the pull-up, then the board
  assign padIn = (padOe & padOut) | (~padOe & padPullUp)
               | (~padOe & ~padPullUp & extLvl);
endmodule : ppm_pad_model

// ---- ppm_pin_mux_tb.sv ----
`timescale 1ns/10ps
module ppm_pin_mux_tb import ppm_pkg::*; ;
  logic            sys_clk = 1'b0;
  logic            rstn = 1'b0;
  logic            wbCyc = 1'b0;
  logic            wbStb = 1'b0;
  logic            wbWe = 1'b0;
  logic [7:0]      wbAdr = 8'h00;
  logic [31:0]     wbDatW = 32'h0;
  logic [3:0]      wbSel = 4'hF;
  logic            wbAck;
  logic [31:0]     wbDatR;
  logic [31:0]     rdv;
  logic [6:0][7:0] padIn, padOut, padOe, padPull;
  logic [6:0][7:0] extLvl = '0;
  logic [19:0]     segLn = 20'h50A0F;
  logic [7:0]      comLn = 8'hE1;
  logic            buz = 1'b1, pwm = 1'b1, t2o = 1'b0, txd = 1'b1;
  logic            schm, mosc, sosc, rxd, uclk, t0e, rstL;
  logic            irq0, irq1, irq2, irq3;
  logic [5:0]      anaSel;
  logic [5:0]      anaSelSm;
  int              failures = 0;
  int              compares = 0;
  // adr, reset value, written, read back
  logic [31:0] rows [16] = '{
    32'h04_00_FF_D2, 32'h08_00_FF_D2, 32'h0C_00_FF_D2,
    32'h14_00_FF_01, 32'h24_00_FF_3F, 32'h34_00_FF_7E,
    32'h44_00_FF_FF, 32'h54_00_FF_FF, 32'h64_00_FF_00,
    32'h80_00_FF_FF, 32'h84_00_FF_FF, 32'h88_00_FF_FF,
    32'h8C_00_FF_01, 32'h90_30_FF_7F, 32'h94_00_FF_3F,
    32'hA0_00_FF_00};
  always #20 sys_clk = ~sys_clk;
  ppm_pin_mux i_ppm_pin_mux (
    .sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_dat_i(wbDatW), .wb_sel_i(wbSel),
    .wb_ack_o(wbAck), .wb_dat_o(wbDatR), .padIn(padIn), .padOut(padOut),
    .padOe(padOe), .padPullUp(padPull), .port1SchmittEn(schm),
    .analogInputSelect(anaSel), .mainOscEnable(mosc), .subOscEnable(sosc),
    .lcdSegmentLines(segLn), .lcdCommonLines(comLn), .buzzerOutput(buz),
    .timer3PwmOut(pwm), .timer2Output(t2o), .uartTransmitOut(txd),
    .timer0EventInput(t0e), .extIrqZero(irq0), .extIrqOne(irq1),
    .extIrqTwo(irq2), .extIrqThree(irq3), .uartReceiveIn(rxd),
    .uartClockIn(uclk), .resetPinLevel(rstL));
  ppm_pad_model i_ppm_pad_model (.padOut(padOut), .padOe(padOe),
    .padPullUp(padPull), .extLvl(extLvl), .padIn(padIn));
  // small package build, only four analog pins
  ppm_pin_mux #(.SMALL_PACKAGE(1'b1)) i_ppm_pin_mux_sm (
    .sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_dat_i(wbDatW), .wb_sel_i(wbSel),
    .wb_ack_o(), .wb_dat_o(), .padIn(padIn), .padOut(), .padOe(),
    .padPullUp(), .port1SchmittEn(), .analogInputSelect(anaSelSm),
    .mainOscEnable(), .subOscEnable(), .lcdSegmentLines(segLn),
    .lcdCommonLines(comLn), .buzzerOutput(buz), .timer3PwmOut(pwm),
    .timer2Output(t2o), .uartTransmitOut(txd), .timer0EventInput(),
    .extIrqZero(), .extIrqOne(), .extIrqTwo(), .extIrqThree(),
    .uartReceiveIn(), .uartClockIn(), .resetPinLevel());
  // ======
  // tasks
  task automatic close_out;
    if (failures == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // held until ack is sampled, then released for one cycle
  task automatic bus(input logic we, input logic [7:0] a,
                     input logic [7:0] d, input logic s);
    int n;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbDatW <= {24'h0, d};
    wbSel <= {3'h7, s};
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    if (n == 20) begin
      failures++;
      close_out();
    end else begin
      rdv = wbDatR;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      @(posedge sys_clk);
    end
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 1'b1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00, 1'b1);
    chk(rdv[7:0], e);
  endtask : rd
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick
  // ======
  // main sequence
  initial begin
    tick(3);
    rstn <= 1'b1;
    tick(1);
    foreach (rows[i]) begin
      rd(rows[i][31:24], rows[i][23:16]);
      wr(rows[i][31:24], rows[i][15:8]);
      rd(rows[i][31:24], rows[i][7:0]);
      wr(rows[i][31:24], rows[i][23:16]);
    end
    extLvl[5] <= 8'h3C;
    wr(8'h50, 8'hA5);
    wr(8'h54, 8'h0F);
    wr(8'h5C, 8'h03);
    wr(8'h58, 8'hF0);
    tick(6);
    chk(padOe[5], 8'h0E);
    chk(padOut[5], 8'h04);
    chk(padPull[5], 8'hF0);
    rd(8'h50, 8'hF4);
    wr(8'h84, 8'h0F);
    tick(6);
    chk(padOe[5], 8'h0F);
    chk(padOut[5], 8'h0A);
    rd(8'h50, 8'hF0);
    comLn <= 8'h1E;
    wr(8'h88, 8'hFF);
    tick(6);
    chk(padOut[6], 8'h78);
    chk(padOe[6], 8'hFF);
    wr(8'h8C, 8'h01);
    tick(6);
    chk(padOut[6], 8'h75);
    wr(8'h80, 8'h01);
    tick(6);
    chk({rxd, uclk, 6'h0}, 8'h80);
    extLvl[4] <= 8'h04;
    segLn <= 20'hA0A08;
    wr(8'h80, 8'h08);
    wr(8'h90, 8'h38);
    tick(6);
    chk(padOut[4], 8'h0A);
    chk(padOe[4], 8'h0A);
    chk({rxd, uclk, 6'h0}, 8'h40);
    extLvl[0] <= 8'h42;
    wr(8'h90, 8'h31);
    tick(8);
    chk(padOut[0], 8'h10);
    chk({t0e, irq0, irq1, 5'h0}, 8'hC0);
    buz <= 1'b0;
    extLvl[0] <= 8'h80;
    tick(8);
    chk(padOut[0], 8'h00);
    chk({t0e, irq0, irq1, 5'h0}, 8'h20);
    wr(8'h90, 8'h72);
    tick(6);
    chk(padOut[1], 8'h01);
    chk({schm, mosc, sosc, 5'h0}, 8'hE0);
    pwm <= 1'b0;
    t2o <= 1'b1;
    wr(8'h90, 8'h76);
    tick(6);
    chk(padOut[1], 8'h01);
    chk(padOe[1], 8'h01);
    wr(8'h14, 8'h01);
    tick(4);
    chk({schm, mosc, sosc, 5'h0}, 8'h60);
    extLvl[3] <= 8'h92;
    tick(8);
    chk({irq2, irq3, rstL, 5'h0}, 8'hE0);
    wr(8'h90, 8'h00);
    tick(2);
    chk({schm, mosc, sosc, 5'h0}, 8'h00);
    extLvl[2] <= 8'hFF;
    wr(8'h94, 8'h3F);
    chk({2'h0, anaSel}, 8'h3F);
    chk({2'h0, anaSelSm}, 8'h0F);
    tick(6);
    rd(8'h20, 8'h00);
    wr(8'h94, 8'h00);
    rd(8'h20, 8'h3F);
    bus(1'b1, 8'h94, 8'h15, 1'b0);
    rd(8'h94, 8'h00);
    rstn <= 1'b0;
    tick(4);
    rstn <= 1'b1;
    tick(1);
    rd(8'h90, 8'h30);
    rd(8'h88, 8'h00);
    close_out();
  end
endmodule : ppm_pin_mux_tb
